// ===== ppm_pkg.sv
package ppm_pkg;
   // Power mode selection encoding in the power-mode control register
   localparam logic [1:0] PPM_SEL_FULL = 2'h0;
   localparam logic [1:0] PPM_SEL_DOZE = 2'h1;
   localparam logic [1:0] PPM_SEL_NAP  = 2'h2;
   localparam logic [1:0] PPM_SEL_SLEEP = 2'h3;
   localparam logic [1:0] PPM_RST_SEL  = 2'h0;

   typedef enum logic [2:0] {
      PPM_ST_FULL    = 3'h0,
      PPM_ST_DOZE    = 3'h1,
      PPM_ST_NAP     = 3'h2,
      PPM_ST_NAP_PCI = 3'h3,
      PPM_ST_SLEEP   = 3'h4
   } ppm_state_t;
endpackage

// ===== ppm_power_mode_ctrl.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Doze entered on software doze selection alone, no core handshake.
// - Doze and nap keep PCI decode, arbiter, refresh, interrupts, I2C, PLL on.
// - Nap or sleep only when selected and core quiesce request is high.
// - Sleep stops PCI decode, keeps arbiter; refresh and PLL follow disable bits.
// - Bus request and NMI monitoring, interrupts and I2C stay on in all modes.
// - Doze wakes on PCI memory access, bus request, NMI, interrupt or reset.
// - NMI wakes only while machine-check enable is set.
// - Sleep wakes on bus request, enabled NMI, interrupt or reset; not PCI.
// - PCI access during nap keeps the quiesce acknowledge asserted.
// - PCI access during nap is not passed to the core for snooping.
// - After a nap PCI access the logic returns to nap on its own.
// - Dropping quiesce acknowledge wakes the core.
// - Logic is fully static; state held through all modes.
module ppm_power_mode_ctrl
   import ppm_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic [1:0] power_mode_control_reg,
   input  wire logic       mcp_enable,
   input  wire logic       sleep_refresh_disable,
   input  wire logic       sleep_pll_disable,
   input  wire logic       core_quiesce_request,
   input  wire logic       pci_mem_access,
   input  wire logic       pci_access_done,
   input  wire logic       cpu_bus_request,
   input  wire logic       nmi_in,
   input  wire logic       irq_in,
   output logic            core_quiesce_acknowledge,
   output logic            pci_decode_en,
   output logic            pci_arbiter_en,
   output logic            refresh_en,
   output logic            pll_en,
   output logic            intc_en,
   output logic            i2c_en,
   output logic            req_monitor_en,
   output logic            snoop_en,
   output logic [2:0]      power_state
);
   ppm_state_t state;
   ppm_state_t next_state;
   logic       wake_common;
   logic       next_ack;
   logic       next_pci_decode;
   logic       next_refresh;
   logic       next_pll;
   logic       next_snoop;

   // Enabled NMI, bus request and interrupt wake every reduced mode
   assign wake_common = cpu_bus_request | irq_in | (nmi_in & mcp_enable);

   always_comb begin
      next_state = state;
      case (state)
         PPM_ST_FULL: begin
            if ((power_mode_control_reg == PPM_SEL_NAP) && core_quiesce_request) begin
               next_state = PPM_ST_NAP;
            end else if ((power_mode_control_reg == PPM_SEL_SLEEP) && core_quiesce_request) begin
               next_state = PPM_ST_SLEEP;
            end else if (power_mode_control_reg == PPM_SEL_DOZE) begin
               next_state = PPM_ST_DOZE;
            end
         end
         PPM_ST_DOZE: begin
            if (wake_common || pci_mem_access || power_mode_control_reg != PPM_SEL_DOZE) begin
               next_state = PPM_ST_FULL;
            end
         end
         PPM_ST_NAP: begin
            // Core dropping its request also ends nap, else ack would hang
            if (wake_common || !core_quiesce_request) begin
               next_state = PPM_ST_FULL;
            end else if (pci_mem_access) begin
               next_state = PPM_ST_NAP_PCI;
            end
         end
         PPM_ST_NAP_PCI: begin
            if (wake_common || !core_quiesce_request) begin
               next_state = PPM_ST_FULL;
            end else if (pci_access_done) begin
               next_state = PPM_ST_NAP;
            end
         end
         PPM_ST_SLEEP: begin
            // PCI memory access deliberately absent here
            if (wake_common || !core_quiesce_request) begin
               next_state = PPM_ST_FULL;
            end
         end
         default: next_state = PPM_ST_FULL;
      endcase
   end

   // Built from next_state so every output switches together with power_state
   always_comb begin
      next_ack        = (next_state == PPM_ST_NAP) || (next_state == PPM_ST_NAP_PCI)
                        || (next_state == PPM_ST_SLEEP);
      next_pci_decode = (next_state != PPM_ST_SLEEP);
      next_refresh    = (next_state != PPM_ST_SLEEP) || !sleep_refresh_disable;
      next_pll        = (next_state != PPM_ST_SLEEP) || !sleep_pll_disable;
      next_snoop      = (next_state == PPM_ST_FULL) || (next_state == PPM_ST_DOZE);
   end

   // Plain flops, no clock gating of state: contents survive every mode
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state                    <= PPM_ST_FULL;
         core_quiesce_acknowledge <= 1'b0;
         pci_decode_en            <= 1'b1;
         refresh_en               <= 1'b1;
         pll_en                   <= 1'b1;
         snoop_en                 <= 1'b1;
         power_state              <= PPM_ST_FULL;
      end else begin
         state                    <= next_state;
         core_quiesce_acknowledge <= next_ack;
         pci_decode_en            <= next_pci_decode;
         refresh_en               <= next_refresh;
         pll_en                   <= next_pll;
         snoop_en                 <= next_snoop;
         power_state              <= next_state;
      end
   end

   // Always-on units, registered so outputs come from flops
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pci_arbiter_en <= 1'b1;
         intc_en        <= 1'b1;
         i2c_en         <= 1'b1;
         req_monitor_en <= 1'b1;
      end else begin
         pci_arbiter_en <= 1'b1;
         intc_en        <= 1'b1;
         i2c_en         <= 1'b1;
         req_monitor_en <= 1'b1;
      end
   end

   a_nap_entry_qual: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_FULL && next_state inside {PPM_ST_NAP, PPM_ST_SLEEP})
      |-> core_quiesce_request && power_mode_control_reg[1])
      else $error("nap or sleep entered without selection and request");
   a_doze_entry: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_FULL && power_mode_control_reg == PPM_SEL_DOZE)
      |=> state == PPM_ST_DOZE)
      else $error("doze not entered");
   a_doze_pci_wake: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_DOZE && pci_mem_access) |=> state == PPM_ST_FULL)
      else $error("doze did not wake on PCI access");
   a_nmi_gate: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_SLEEP && nmi_in && !mcp_enable && !cpu_bus_request && !irq_in
       && core_quiesce_request) |=> state == PPM_ST_SLEEP)
      else $error("NMI woke sleep while machine check disabled");
   a_sleep_no_pci: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_SLEEP && !wake_common && core_quiesce_request)
      |=> state == PPM_ST_SLEEP && !pci_decode_en)
      else $error("sleep left without wake event");
   a_nap_pci_ack: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_NAP_PCI) |-> core_quiesce_acknowledge && !snoop_en)
      else $error("ack dropped or snoop on during nap PCI access");
   a_nap_return: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_NAP_PCI && pci_access_done && !wake_common && core_quiesce_request)
      |=> state == PPM_ST_NAP)
      else $error("no return to nap after PCI access");
   a_wake_drops_ack: assert property (@(posedge mclk) disable iff (!rstn)
      (state inside {PPM_ST_NAP, PPM_ST_NAP_PCI, PPM_ST_SLEEP} && wake_common)
      |=> !core_quiesce_acknowledge)
      else $error("ack not dropped on wake");
   a_sleep_pll: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_SLEEP && $past(state) == PPM_ST_SLEEP && !$past(sleep_pll_disable))
      |-> pll_en && pci_arbiter_en)
      else $error("PLL or arbiter stopped in sleep");

   // Unit enables are levels tied to the registered mode, checked every cycle
   a_doze_nap_units: assert property (@(posedge mclk) disable iff (!rstn)
      (state inside {PPM_ST_DOZE, PPM_ST_NAP, PPM_ST_NAP_PCI})
      |-> pci_decode_en && pci_arbiter_en && refresh_en && pll_en)
      else $error("unit stopped in doze or nap");
   a_always_on: assert property (@(posedge mclk) disable iff (!rstn)
      intc_en && i2c_en && req_monitor_en && pci_arbiter_en)
      else $error("always-on unit stopped");
   a_sleep_refresh: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_SLEEP)
      |-> !pci_decode_en && (refresh_en == !$past(sleep_refresh_disable)))
      else $error("refresh or decode wrong in sleep");
   a_sleep_pll_off: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_SLEEP) |-> (pll_en == !$past(sleep_pll_disable)))
      else $error("PLL does not follow its disable in sleep");
   a_full_refused: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_FULL && power_mode_control_reg == PPM_SEL_NAP && !core_quiesce_request)
      |=> state == PPM_ST_FULL)
      else $error("nap entered without core request");
   a_doze_wake: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_DOZE && (cpu_bus_request || irq_in || (nmi_in && mcp_enable)))
      |=> state == PPM_ST_FULL)
      else $error("doze did not wake on event");
   a_doze_hold: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_DOZE && !wake_common && !pci_mem_access
       && power_mode_control_reg == PPM_SEL_DOZE) |=> state == PPM_ST_DOZE)
      else $error("doze state not held");
   a_nmi_wake: assert property (@(posedge mclk) disable iff (!rstn)
      (state inside {PPM_ST_NAP, PPM_ST_NAP_PCI, PPM_ST_SLEEP} && nmi_in && mcp_enable)
      |=> state == PPM_ST_FULL)
      else $error("enabled NMI did not wake");
   a_sleep_wake: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_SLEEP && (cpu_bus_request || irq_in))
      |=> state == PPM_ST_FULL && !core_quiesce_acknowledge)
      else $error("sleep did not wake on request or interrupt");
   a_nap_pci_entry: assert property (@(posedge mclk) disable iff (!rstn)
      (state == PPM_ST_NAP && pci_mem_access && !wake_common && core_quiesce_request)
      |=> state == PPM_ST_NAP_PCI && core_quiesce_acknowledge)
      else $error("PCI access in nap dropped the acknowledge");
   a_snoop_level: assert property (@(posedge mclk) disable iff (!rstn)
      snoop_en == (state inside {PPM_ST_FULL, PPM_ST_DOZE}))
      else $error("snoop enable wrong for mode");
   a_ack_level: assert property (@(posedge mclk) disable iff (!rstn)
      core_quiesce_acknowledge == (state inside {PPM_ST_NAP, PPM_ST_NAP_PCI, PPM_ST_SLEEP}))
      else $error("acknowledge wrong for mode");
endmodule

// ===== ppm_core_model.sv
`timescale 1ns/1ns
module ppm_core_model (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic go_nap,
   input  wire logic core_quiesce_acknowledge,
   output logic      core_quiesce_request
);
   logic acked;
   logic next_req;
   // Core naps on command, wakes when the acknowledge falls
   always_comb begin
      if (acked && !core_quiesce_acknowledge) begin
         next_req = 1'b0;
      end else begin
         next_req = go_nap;
      end
   end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         core_quiesce_request <= 1'b0;
         acked                <= 1'b0;
      end else begin
         core_quiesce_request <= next_req;
         acked                <= core_quiesce_acknowledge;
      end
   end
endmodule

// ===== tb_ppm_power_mode_ctrl.sv
`timescale 1ns/1ns
module tb_ppm_power_mode_ctrl import ppm_pkg::*; ;
   logic       mclk = 1'b0, rstn = 1'b0, mcp = 1'b0, srd = 1'b0, spd = 1'b0;
   logic       pma = 1'b0, pad = 1'b0, cbr = 1'b0, nmi = 1'b0, irq = 1'b0;
   logic       go_nap = 1'b0;
   logic [1:0] sel = PPM_SEL_FULL;
   logic       req, ack, dec, arb, refr, pll, intc, i2c, mon, snoop;
   logic [2:0] st;
   int         n_mismatch = 0, tests_run = 0, cyc = 0;
   wire logic [11:0] obs = {st, ack, snoop, dec, refr, pll, arb, intc, i2c, mon};
   initial begin
      forever #4 mclk = ~mclk;
   end
   ppm_core_model i_ppm_core_model (.mclk(mclk), .rstn(rstn), .go_nap(go_nap),
      .core_quiesce_acknowledge(ack), .core_quiesce_request(req));
   ppm_power_mode_ctrl i_ppm_power_mode_ctrl (.mclk(mclk), .rstn(rstn),
      .power_mode_control_reg(sel), .mcp_enable(mcp), .sleep_refresh_disable(srd),
      .sleep_pll_disable(spd), .core_quiesce_request(req), .pci_mem_access(pma),
      .pci_access_done(pad), .cpu_bus_request(cbr), .nmi_in(nmi), .irq_in(irq),
      .core_quiesce_acknowledge(ack), .pci_decode_en(dec), .pci_arbiter_en(arb),
      .refresh_en(refr), .pll_en(pll), .intc_en(intc), .i2c_en(i2c),
      .req_monitor_en(mon), .snoop_en(snoop), .power_state(st));
   task automatic step(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Whole run is about 40 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 400) begin
         n_mismatch++;
         test_done();
      end
   end
   initial begin
      step(10);
      rstn = 1'b1;
      chk("reset", obs, {PPM_ST_FULL, 9'h0FF});
      sel = PPM_SEL_NAP;
      step(2);
      chk("nap unrequested", obs, {PPM_ST_FULL, 9'h0FF});
      $display("test refuse done");
      sel = PPM_SEL_DOZE;
      step(1);
      chk("doze", obs, {PPM_ST_DOZE, 9'h0FF});
      nmi = 1'b1;
      step(1);
      chk("masked nmi", obs, {PPM_ST_DOZE, 9'h0FF});
      nmi = 1'b0;
      irq = 1'b1;
      step(1);
      irq = 1'b0;
      sel = PPM_SEL_FULL;
      chk("doze wake", obs, {PPM_ST_FULL, 9'h0FF});
      $display("test doze done");
      sel = PPM_SEL_NAP;
      go_nap = 1'b1;
      step(2);
      chk("nap", obs, {PPM_ST_NAP, 9'h17F});
      pma = 1'b1;
      step(1);
      pma = 1'b0;
      chk("nap pci", obs, {PPM_ST_NAP_PCI, 9'h17F});
      pad = 1'b1;
      step(1);
      pad = 1'b0;
      chk("nap again", obs, {PPM_ST_NAP, 9'h17F});
      mcp = 1'b1;
      nmi = 1'b1;
      step(1);
      nmi = 1'b0;
      sel = PPM_SEL_FULL;
      chk("nap wake", obs, {PPM_ST_FULL, 9'h0FF});
      step(1);
      chk("core awake", {11'h000, req}, 12'h000);
      $display("test nap done");
      sel = PPM_SEL_SLEEP;
      mcp = 1'b0;
      srd = 1'b1;
      step(2);
      chk("sleep", obs, {PPM_ST_SLEEP, 9'h11F});
      pma = 1'b1;
      nmi = 1'b1;
      step(1);
      pma = 1'b0;
      nmi = 1'b0;
      chk("sleep pci", obs, {PPM_ST_SLEEP, 9'h11F});
      cbr = 1'b1;
      step(1);
      cbr = 1'b0;
      sel = PPM_SEL_FULL;
      go_nap = 1'b0;
      chk("sleep wake", obs, {PPM_ST_FULL, 9'h0FF});
      $display("test sleep done");
      step(1);
      sel = PPM_SEL_DOZE;
      step(1);
      pma = 1'b1;
      step(1);
      pma = 1'b0;
      chk("doze pci wake", obs, {PPM_ST_FULL, 9'h0FF});
      step(1);
      chk("doze again", obs, {PPM_ST_DOZE, 9'h0FF});
      cbr = 1'b1;
      step(1);
      cbr = 1'b0;
      sel = PPM_SEL_FULL;
      chk("doze request wake", obs, {PPM_ST_FULL, 9'h0FF});
      $display("test doze wake done");
      step(1);
      sel = PPM_SEL_SLEEP;
      go_nap = 1'b1;
      srd = 1'b0;
      spd = 1'b1;
      step(2);
      chk("sleep pll off", obs, {PPM_ST_SLEEP, 9'h12F});
      irq = 1'b1;
      step(1);
      irq = 1'b0;
      sel = PPM_SEL_FULL;
      go_nap = 1'b0;
      chk("sleep irq wake", obs, {PPM_ST_FULL, 9'h0FF});
      $display("test sleep pll done");
      step(1);
      sel = PPM_SEL_DOZE;
      step(1);
      chk("doze before reset", obs, {PPM_ST_DOZE, 9'h0FF});
      rstn = 1'b0;
      sel = PPM_SEL_FULL;
      step(1);
      chk("mid reset", obs, {PPM_ST_FULL, 9'h0FF});
      rstn = 1'b1;
      step(2);
      chk("after reset", obs, {PPM_ST_FULL, 9'h0FF});
      $display("test reset done");
      test_done();
   end
endmodule
